// >>> hw/usb_ep0_pkg.sv
// Constants and types shared by the host endpoint 0 and bulk IN receive logic
package usb_ep0_pkg;
   localparam int         ADDR_W           = 8;
   localparam int         LIMIT_W          = 16;
   localparam int         FIFO_AW          = 4;
   localparam int         DATA_W           = 32;
   // Register byte offsets
   localparam logic [7:0] OFF_EP0_CSR      = 8'h00;
   localparam logic [7:0] OFF_EP0_LIMIT    = 8'h04;
   localparam logic [7:0] OFF_EP0_FIFO     = 8'h08;
   localparam logic [7:0] OFF_RX_CSR       = 8'h0c;
   localparam logic [7:0] OFF_RX_FIFO_SIZE = 8'h10;
   localparam logic [7:0] OFF_AUTO_REQ     = 8'h14;
   localparam logic [7:0] OFF_RX_LIMIT     = 8'h18;
   // Endpoint 0 control/status fields
   localparam int         B_RX_WAIT        = 0;
   localparam int         B_TX_LOADED      = 1;
   localparam int         B_STALL          = 2;
   localparam int         B_ERROR          = 4;
   localparam int         B_IN_REQ         = 5;
   localparam int         B_STATUS         = 6;
   localparam int         B_NAK_TO         = 7;
   localparam int         B_FLUSH          = 8;
   // Receive endpoint control/status fields, then FIFO size and auto request register fields
   localparam int         RB_RX_WAIT       = 0;
   localparam int         RB_ERROR         = 2;
   localparam int         RB_NAK_TO        = 3;
   localparam int         RB_IN_REQ        = 5;
   localparam int         RB_STALL         = 6;
   localparam int         RB_DMA_EN        = 13;
   localparam int         B_DOUBLE_BUF     = 4;
   localparam int         B_AUTO_REQ       = 0;
   // Retry figures
   localparam logic [1:0] NOREPLY_LAST     = 2'h2;
   localparam logic [15:0] LIMIT_MIN       = 16'h0002;
   localparam logic [15:0] LIMIT_RESET     = 16'h0000;

   typedef enum logic [2:0] {
      RESP_ACK   = 3'b000,
      RESP_NAK   = 3'b001,
      RESP_STALL = 3'b010,
      RESP_DATA  = 3'b011,
      RESP_NONE  = 3'b100
   } resp_t;

   typedef enum logic [2:0] {
      OUT_OK     = 3'b000,
      OUT_DATA   = 3'b001,
      OUT_STALL  = 3'b010,
      OUT_ERROR  = 3'b011,
      OUT_NAK_TO = 3'b100
   } outcome_t;

   typedef enum logic [1:0] {
      TOK_IN  = 2'b00,
      TOK_OUT = 2'b01
   } token_t;
endpackage

// >>> hw/token_retry.sv
// Token issue and retry sequencer for one host endpoint
`timescale 1ns/1ps
module token_retry import usb_ep0_pkg::*; (
   input  logic               core_clk,
   input  logic               rst_n,
   input  logic               start,
   input  logic [LIMIT_W-1:0] nak_limit,
   input  logic               frame_tick,
   input  logic               resp_valid,
   input  resp_t              resp_code,
   output logic               tok_go,
   output logic               busy,
   output logic               done,
   output outcome_t           outcome
);
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ISSUE = 2'b01,
      ST_WAIT  = 2'b10
   } state_t;

   state_t             state_q;
   logic [1:0]         tries_q;
   logic               nak_seen_q;
   logic [LIMIT_W-1:0] nak_frames_q;
   logic [LIMIT_W-1:0] eff_limit;
   logic               expired;
   logic               retry;

   // Limits below the floor are raised to it; zero switches the timeout off
   assign eff_limit = (nak_limit < LIMIT_MIN) ? LIMIT_MIN : nak_limit;
   assign expired   = (nak_limit != '0) && (nak_frames_q >= eff_limit);
   assign retry     = ((resp_code == RESP_NAK) && !expired) ||
                      ((resp_code == RESP_NONE) && (tries_q != NOREPLY_LAST));
   assign tok_go    = (state_q == ST_ISSUE);
   assign busy      = (state_q != ST_IDLE);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE:  state_q <= start ? ST_ISSUE : ST_IDLE;
            ST_ISSUE: state_q <= ST_WAIT;
            ST_WAIT: begin
               if (resp_valid) begin
                  state_q <= retry ? ST_ISSUE : ST_IDLE;
               end
            end
            default:  state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tries_q <= 2'h0;
      end else if (start && !busy) begin
         tries_q <= 2'h0;
      end else if (state_q == ST_WAIT && resp_valid && resp_code == RESP_NONE) begin
         tries_q <= tries_q + 2'h1;
      end
   end

   // Frames are counted from the first NAK until the transaction ends
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         nak_seen_q   <= 1'b0;
         nak_frames_q <= '0;
      end else if (start && !busy) begin
         nak_seen_q   <= 1'b0;
         nak_frames_q <= '0;
      end else begin
         if (state_q == ST_WAIT && resp_valid && resp_code == RESP_NAK) begin
            nak_seen_q <= 1'b1;
         end
         if (busy && nak_seen_q && frame_tick && nak_frames_q != '1) begin
            nak_frames_q <= nak_frames_q + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         done    <= 1'b0;
         outcome <= OUT_OK;
      end else begin
         done <= (state_q == ST_WAIT) && resp_valid && !retry;
         if (state_q == ST_WAIT && resp_valid) begin
            case (resp_code)
               RESP_ACK:   outcome <= OUT_OK;
               RESP_DATA:  outcome <= OUT_DATA;
               RESP_STALL: outcome <= OUT_STALL;
               RESP_NAK:   outcome <= OUT_NAK_TO;
               default:    outcome <= OUT_ERROR;
            endcase
         end
      end
   end

   a_err_three: assert property (@(posedge core_clk) disable iff (!rst_n)
      done && outcome == OUT_ERROR |-> tries_q == 2'h3)
      else $error("error reported before three unanswered attempts");

   a_nak_expiry: assert property (@(posedge core_clk) disable iff (!rst_n)
      done && outcome == OUT_NAK_TO |-> nak_limit != '0 && nak_frames_q >= eff_limit)
      else $error("NAK timeout reported before the limit ran out");
endmodule

// >>> hw/usb_host_ep0_ctrl.sv
// Host endpoint 0 control stages and bulk IN receive endpoint, AHB-Lite registers
// Overview of operation
// - Setting IN request sends an IN token, collects data, then signals endpoint 0 event
// - Control/status shows stall bit 2, error bit 4, NAK timeout bit 7, packet bit 0
// - A STALL handshake sets the stall flag
// - Three unanswered IN tokens set the error flag
// - NAKed tokens retry until the NAK limit passes, then flag NAK timeout
// - Clearing only the NAK timeout flag resumes the same transaction
// - Setting transmit loaded sends OUT token and FIFO data, then signals event
// - Three unanswered OUT data attempts set the error flag
// - An acknowledged OUT packet leaves stall, error and timeout flags clear
// - Status plus IN request sends an IN status token and captures reply
// - Status plus transmit loaded together send OUT token and zero-length DATA1
// - Three unanswered OUT status attempts set the error flag
// - Double-buffer bit 4 lets the receive FIFO hold two packets
// - With DMA enabled, request DMA while the receive FIFO holds a packet
// - With DMA enabled, every outcome except a received data packet raises the receive endpoint event
// - Auto request with DMA sets IN request when the packet flag clears
// - NAK limit is programmable in frames with a floor of two
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module usb_host_ep0_ctrl import usb_ep0_pkg::*; #(
   parameter int FIFO_DEPTH_LOG2 = FIFO_AW
) (
   input  logic              core_clk,
   input  logic              rst_n,
   input  logic              hsel,
   input  logic [31:0]       haddr,
   input  logic [1:0]        htrans,
   input  logic              hwrite,
   input  logic [2:0]        hsize,
   input  logic [31:0]       hwdata,
   input  logic              hready,
   output logic              hreadyout,
   output logic              hresp,
   output logic [31:0]       hrdata,
   input  logic              frame_tick,
   output logic              tok_go,
   output token_t            tok_kind,
   output logic              tok_rx_ep,
   output logic              tok_status_zlp,
   input  logic              resp_valid,
   input  resp_t             resp_code,
   input  logic              ep0_rx_push,
   input  logic [DATA_W-1:0] ep0_rx_word,
   input  logic              ep0_tx_pop,
   output logic [DATA_W-1:0] ep0_tx_word,
   output logic              ep0_tx_empty,
   input  logic              dma_pkt_done,
   output logic              dma_req,
   output logic              ep0_event,
   output logic              rx_ep_event
);
   localparam int DEPTH = 1 << FIFO_DEPTH_LOG2;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // Bus slave state
   logic                  wr_q;
   logic [ADDR_W-1:0]     waddr_q;
   logic [31:0]           hrdata_q;
   logic                  aph;
   logic                  sw_pop;
   logic                  wr_ep0;
   logic                  wr_rx;
   // Endpoint 0 flags and limit
   logic                  rx_wait_q;
   logic                  tx_loaded_q;
   logic                  stall_q;
   logic                  err_q;
   logic                  in_req_q;
   logic                  status_q;
   logic                  nak_q;
   logic [LIMIT_W-1:0]    ep0_limit_q;
   // Receive endpoint state
   logic                  rx_in_req_q;
   logic                  rx_stall_q;
   logic                  rx_err_q;
   logic                  rx_nak_q;
   logic                  dma_en_q;
   logic                  dbl_q;
   logic                  auto_q;
   logic [1:0]            rx_cnt_q;
   logic [LIMIT_W-1:0]    rx_limit_q;
   logic                  rx_pop;
   logic                  rx_full;
   // Endpoint 0 FIFO
   logic [DATA_W-1:0]     mem [DEPTH];
   logic [FIFO_DEPTH_LOG2:0] wp_q;
   logic [FIFO_DEPTH_LOG2:0] rp_q;
   logic                  f_full;
   logic                  f_empty;
   logic                  f_push;
   logic                  f_pop;
   logic                  flush;
   // Sequencers
   logic                  owner_q;
   logic                  ep0_start;
   logic                  rx_start;
   logic                  ep0_go;
   logic                  rx_go;
   logic                  ep0_busy;
   logic                  rx_busy;
   logic                  ep0_done;
   logic                  rx_done;
   outcome_t              ep0_out;
   outcome_t              rx_out;

   assign aph       = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;
   assign sw_pop    = aph && !hwrite && hit(haddr[ADDR_W-1:0], OFF_EP0_FIFO);
   assign wr_ep0    = wr_q && hit(waddr_q, OFF_EP0_CSR);
   assign wr_rx     = wr_q && hit(waddr_q, OFF_RX_CSR);
   assign flush     = wr_ep0 && hwdata[B_FLUSH];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q    <= 1'b0;
         waddr_q <= '0;
      end else begin
         wr_q    <= aph && hwrite;
         waddr_q <= aph ? haddr[ADDR_W-1:0] : waddr_q;
      end
   end

   // Read data is taken in the address phase so it leaves a flop in the data phase
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata_q <= 32'h0000_0000;
      end else if (aph && !hwrite) begin
         hrdata_q <= 32'h0000_0000;
         case (haddr[ADDR_W-1:0])
            OFF_EP0_CSR: begin
               hrdata_q[B_RX_WAIT]   <= rx_wait_q;
               hrdata_q[B_TX_LOADED] <= tx_loaded_q;
               hrdata_q[B_STALL]     <= stall_q;
               hrdata_q[B_ERROR]     <= err_q;
               hrdata_q[B_IN_REQ]    <= in_req_q;
               hrdata_q[B_STATUS]    <= status_q;
               hrdata_q[B_NAK_TO]    <= nak_q;
            end
            OFF_EP0_LIMIT:    hrdata_q[LIMIT_W-1:0] <= ep0_limit_q;
            OFF_EP0_FIFO:     hrdata_q <= f_empty ? 32'h0000_0000 : mem[rp_q[FIFO_DEPTH_LOG2-1:0]];
            OFF_RX_CSR: begin
               hrdata_q[RB_RX_WAIT] <= (rx_cnt_q != 2'h0);
               hrdata_q[RB_ERROR]   <= rx_err_q;
               hrdata_q[RB_NAK_TO]  <= rx_nak_q;
               hrdata_q[RB_IN_REQ]  <= rx_in_req_q;
               hrdata_q[RB_STALL]   <= rx_stall_q;
               hrdata_q[RB_DMA_EN]  <= dma_en_q;
            end
            OFF_RX_FIFO_SIZE: hrdata_q[B_DOUBLE_BUF] <= dbl_q;
            OFF_AUTO_REQ:     hrdata_q[B_AUTO_REQ] <= auto_q;
            OFF_RX_LIMIT:     hrdata_q[LIMIT_W-1:0] <= rx_limit_q;
            default:          hrdata_q <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ep0_limit_q <= LIMIT_RESET;
         rx_limit_q  <= LIMIT_RESET;
         dbl_q       <= 1'b0;
         auto_q      <= 1'b0;
      end else if (wr_q) begin
         if (hit(waddr_q, OFF_EP0_LIMIT)) ep0_limit_q <= hwdata[LIMIT_W-1:0];
         if (hit(waddr_q, OFF_RX_LIMIT)) rx_limit_q <= hwdata[LIMIT_W-1:0];
         if (hit(waddr_q, OFF_RX_FIFO_SIZE)) dbl_q <= hwdata[B_DOUBLE_BUF];
         if (hit(waddr_q, OFF_AUTO_REQ)) auto_q <= hwdata[B_AUTO_REQ];
      end
   end

   // Endpoint 0 FIFO; the link side has priority when both sides push in one cycle
   assign f_full       = (wp_q[FIFO_DEPTH_LOG2] != rp_q[FIFO_DEPTH_LOG2]) &&
                         (wp_q[FIFO_DEPTH_LOG2-1:0] == rp_q[FIFO_DEPTH_LOG2-1:0]);
   assign f_empty      = (wp_q == rp_q);
   assign f_push       = (ep0_rx_push || (wr_q && hit(waddr_q, OFF_EP0_FIFO))) && !f_full;
   assign f_pop        = (ep0_tx_pop || sw_pop) && !f_empty;
   assign ep0_tx_word  = mem[rp_q[FIFO_DEPTH_LOG2-1:0]];
   assign ep0_tx_empty = f_empty;

   always_ff @(posedge core_clk) begin
      if (f_push) begin
         mem[wp_q[FIFO_DEPTH_LOG2-1:0]] <= ep0_rx_push ? ep0_rx_word : hwdata;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
      end else if (flush) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (f_push) wp_q <= wp_q + 1'b1;
         if (f_pop) rp_q <= rp_q + 1'b1;
      end
   end

   // Endpoint 0 flags: a write applies first, an outcome overrides it in the same cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_wait_q   <= 1'b0;
         tx_loaded_q <= 1'b0;
         stall_q     <= 1'b0;
         err_q       <= 1'b0;
         in_req_q    <= 1'b0;
         status_q    <= 1'b0;
         nak_q       <= 1'b0;
      end else begin
         if (wr_ep0) begin
            rx_wait_q   <= rx_wait_q & hwdata[B_RX_WAIT];
            tx_loaded_q <= hwdata[B_TX_LOADED] | (tx_loaded_q & !flush);
            stall_q     <= stall_q & hwdata[B_STALL];
            err_q       <= err_q & hwdata[B_ERROR];
            in_req_q    <= hwdata[B_IN_REQ];
            status_q    <= hwdata[B_STATUS];
            nak_q       <= nak_q & hwdata[B_NAK_TO];
         end
         if (ep0_done) begin
            if (ep0_out != OUT_NAK_TO) begin
               in_req_q    <= 1'b0;
               tx_loaded_q <= 1'b0;
               status_q    <= 1'b0;
            end
            case (ep0_out)
               OUT_OK: begin
                  stall_q <= 1'b0;
                  err_q   <= 1'b0;
                  nak_q   <= 1'b0;
               end
               OUT_DATA:   rx_wait_q <= 1'b1;
               OUT_STALL:  stall_q <= 1'b1;
               OUT_ERROR:  err_q <= 1'b1;
               OUT_NAK_TO: nak_q <= 1'b1;
               default:    nak_q <= nak_q;
            endcase
         end
      end
   end

   // Receive endpoint: a packet slot is freed by software or by the DMA engine
   assign rx_pop  = ((wr_rx && !hwdata[RB_RX_WAIT]) || dma_pkt_done) && (rx_cnt_q != 2'h0);
   assign rx_full = rx_cnt_q >= (dbl_q ? 2'h2 : 2'h1);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_cnt_q <= 2'h0;
      end else begin
         case ({rx_done && rx_out == OUT_DATA, rx_pop})
            2'b10:   rx_cnt_q <= rx_cnt_q + 2'h1;
            2'b01:   rx_cnt_q <= rx_cnt_q - 2'h1;
            default: rx_cnt_q <= rx_cnt_q;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_in_req_q <= 1'b0;
         rx_stall_q  <= 1'b0;
         rx_err_q    <= 1'b0;
         rx_nak_q    <= 1'b0;
         dma_en_q    <= 1'b0;
      end else begin
         if (wr_rx) begin
            rx_in_req_q <= hwdata[RB_IN_REQ];
            rx_stall_q  <= rx_stall_q & hwdata[RB_STALL];
            rx_err_q    <= rx_err_q & hwdata[RB_ERROR];
            rx_nak_q    <= rx_nak_q & hwdata[RB_NAK_TO];
            dma_en_q    <= hwdata[RB_DMA_EN];
         end
         if (rx_pop && auto_q && dma_en_q) begin
            rx_in_req_q <= 1'b1;
         end
         if (rx_done) begin
            if (rx_out != OUT_NAK_TO) rx_in_req_q <= 1'b0;
            if (rx_out == OUT_STALL) rx_stall_q <= 1'b1;
            if (rx_out == OUT_ERROR) rx_err_q <= 1'b1;
            if (rx_out == OUT_NAK_TO) rx_nak_q <= 1'b1;
         end
      end
   end

   assign dma_req = dma_en_q && (rx_cnt_q != 2'h0);

   // One token at a time on the link; endpoint 0 wins a tie. A request restarts
   // on its own once the timeout flag is cleared, so clearing the request first aborts.
   assign ep0_start = (in_req_q || tx_loaded_q) && !nak_q && !ep0_busy && !rx_busy && !ep0_done;
   assign rx_start  = rx_in_req_q && !rx_nak_q && !rx_full && !ep0_busy && !rx_busy && !ep0_start && !rx_done;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         owner_q <= 1'b0;
      end else if (ep0_start) begin
         owner_q <= 1'b0;
      end else if (rx_start) begin
         owner_q <= 1'b1;
      end
   end

   token_retry u_ep0_retry (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .start      (ep0_start),
      .nak_limit  (ep0_limit_q),
      .frame_tick (frame_tick),
      .resp_valid (resp_valid && !owner_q),
      .resp_code  (resp_code),
      .tok_go     (ep0_go),
      .busy       (ep0_busy),
      .done       (ep0_done),
      .outcome    (ep0_out)
   );

   token_retry u_rx_retry (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .start      (rx_start),
      .nak_limit  (rx_limit_q),
      .frame_tick (frame_tick),
      .resp_valid (resp_valid && owner_q),
      .resp_code  (resp_code),
      .tok_go     (rx_go),
      .busy       (rx_busy),
      .done       (rx_done),
      .outcome    (rx_out)
   );

   assign tok_go         = ep0_go || rx_go;
   assign tok_rx_ep      = owner_q;
   assign tok_kind       = (!owner_q && tx_loaded_q) ? TOK_OUT : TOK_IN;
   assign tok_status_zlp = !owner_q && tx_loaded_q && status_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ep0_event   <= 1'b0;
         rx_ep_event <= 1'b0;
      end else begin
         ep0_event   <= ep0_done;
         rx_ep_event <= rx_done && !(dma_en_q && rx_out == OUT_DATA);
      end
   end

   a_stall_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
      ep0_done && ep0_out == OUT_STALL |=> stall_q && !in_req_q && !tx_loaded_q)
      else $error("STALL outcome did not set the stall flag");

   a_ep0_event: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(ep0_busy) |=> ep0_event)
      else $error("endpoint 0 sequence ended without an event");

   a_ack_clean: assert property (@(posedge core_clk) disable iff (!rst_n)
      ep0_done && ep0_out == OUT_OK |=> !stall_q && !err_q && !nak_q && ep0_event)
      else $error("acknowledged packet left an outcome flag set");

   a_dma_req: assert property (@(posedge core_clk) disable iff (!rst_n)
      dma_en_q && rx_done && rx_out == OUT_DATA |=> dma_req)
      else $error("stored packet raised no DMA request");

   a_dma_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      rx_done && rx_out == OUT_DATA && dma_en_q |=> !rx_ep_event)
      else $error("event raised for a DMA packet reception");

   a_auto_req: assert property (@(posedge core_clk) disable iff (!rst_n)
      rx_pop && auto_q && dma_en_q && !rx_done |=> rx_in_req_q)
      else $error("auto request did not set IN request");

   a_rx_capacity: assert property (@(posedge core_clk) disable iff (!rst_n)
      rx_done && rx_out == OUT_DATA |-> rx_cnt_q < (dbl_q ? 2'h2 : 2'h1))
      else $error("packet stored with receive FIFO full");

   a_nak_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(nak_q) && (in_req_q || tx_loaded_q) && !rx_busy |=> ep0_busy)
      else $error("cleared timeout did not resume the transaction");
endmodule

// >>> tb/usb_peer_model.sv
// Behavioural peripheral that answers each host token
`timescale 1ns/1ps
module usb_peer_model import usb_ep0_pkg::*; (
   input  logic   core_clk,
   input  logic   tok_go,
   input  token_t tok_kind,
   input  logic   tx_empty,
   input  resp_t  reply,
   output logic   resp_valid,
   output resp_t  resp_code,
   output logic   rx_push,
   output logic   tx_pop
);
   logic [2:0] cnt_q = 3'h0;
   always_ff @(posedge core_clk) begin
      cnt_q <= tok_go ? 3'h4 : (cnt_q != 3'h0 ? cnt_q - 3'h1 : 3'h0);
   end
   // Slow answer; code is scrambled outside the answer cycle
   assign resp_valid = cnt_q == 3'h1;
   assign resp_code  = resp_valid ? reply : resp_t'(~reply);
   assign rx_push    = cnt_q == 3'h2 && reply == RESP_DATA && tok_kind == TOK_IN;
   assign tx_pop     = cnt_q == 3'h3 && tok_kind == TOK_OUT && !tx_empty;
endmodule

// >>> tb/usb_host_ep0_control_and_bulk_in_tb.sv
// Self-checking bench for the endpoint 0 host sequencer
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; $display("CHECK FAILED %0t value", $time); end end
module usb_host_ep0_control_and_bulk_in_tb import usb_ep0_pkg::*;;
   logic core_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hrdy, rv, push, pop, tgo, zlp, tx_e;
   logic ftick = 0, dma_done = 0, dreq, rxev, rxep, rxep_q;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 0;
   token_t      kind, kind_q;
   resp_t       rsp = RESP_ACK, rcode;
   int          num_errors = 0, n_checks = 0, n_ev = 0, n_tok = 0, n_rxev = 0, cyc = 0;
   logic        ev, zlp_q;
   always #50 core_clk = ~core_clk;
   usb_host_ep0_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(),
      .hrdata(hrdata), .frame_tick(ftick), .tok_go(tgo), .tok_kind(kind), .tok_rx_ep(rxep),
      .tok_status_zlp(zlp), .resp_valid(rv), .resp_code(rcode), .ep0_rx_push(push && !rxep),
      .ep0_rx_word(32'hc3a5_0f96), .ep0_tx_pop(pop), .ep0_tx_word(), .ep0_tx_empty(tx_e),
      .dma_pkt_done(dma_done), .dma_req(dreq), .ep0_event(ev), .rx_ep_event(rxev));
   usb_peer_model peer (.core_clk(core_clk), .tok_go(tgo), .tok_kind(kind), .tx_empty(tx_e), .reply(rsp),
      .resp_valid(rv), .resp_code(rcode), .rx_push(push), .tx_pop(pop));
   always @(posedge core_clk) begin
      n_ev  <= n_ev + int'(ev);
      n_tok <= n_tok + int'(tgo);
      n_rxev <= n_rxev + int'(rxev);
      cyc   <= cyc + 1;
      ftick <= (cyc % 16 == 15);
      if (tgo) begin
         rxep_q <= rxep;
         kind_q <= kind;
         zlp_q  <= zlp;
      end
   end
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1; hsize <= 3'h2; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
      do @(posedge core_clk); while (hrdy !== 1'b1);
      htrans <= 2'h0; hwdata <= d;
      do @(posedge core_clk); while (hrdy !== 1'b1);
      q = hrdata;
   endtask
   task wait_ev();
      int e;
      e = n_ev;
      for (int i = 0; i < 300 && n_ev == e; i++) @(posedge core_clk);
      `CHK(n_ev != e, 1'b1)
   endtask
   // Read request answered with a data packet
   task t_in_data();
      rsp <= RESP_DATA;
      xfer(1, OFF_EP0_CSR, 32'h20);
      wait_ev();
      xfer(0, OFF_EP0_CSR, 0);
      `CHK(q[7:0], 8'h01)
      xfer(0, OFF_EP0_FIFO, 0);
      `CHK(q, 32'hc3a5_0f96)
      xfer(1, OFF_EP0_CSR, 32'h00);
      rsp <= RESP_ACK;
      xfer(1, OFF_EP0_CSR, 32'h42);
      wait_ev();
      `CHK({kind_q, zlp_q}, {TOK_OUT, 1'b1})
      xfer(1, OFF_EP0_CSR, 32'h100);
   endtask
   // Stall answer on an IN token
   task t_stall();
      rsp <= RESP_STALL;
      xfer(1, OFF_EP0_CSR, 32'h20);
      wait_ev();
      xfer(0, OFF_EP0_CSR, 0);
      `CHK(q[7:0], 8'h04)
      xfer(1, OFF_EP0_CSR, 32'h100);
   endtask
   // Silent peer: three attempts, then the error flag
   task t_silent(input logic [31:0] cmd);
      int t0;
      rsp <= RESP_NONE;
      t0 = n_tok;
      xfer(1, OFF_EP0_CSR, cmd);
      wait_ev();
      `CHK(n_tok - t0, 3)
      xfer(0, OFF_EP0_CSR, 0);
      `CHK(q[B_ERROR], 1'b1)
      `CHK(q[B_STALL] | q[B_NAK_TO], 1'b0)
      xfer(1, OFF_EP0_CSR, 32'h100);
   endtask
   // NAKs until the limit runs out, one resume, then the stage is abandoned
   task t_nak(input logic [31:0] cmd, input logic [31:0] drop);
      int t0;
      rsp <= RESP_NAK;
      xfer(1, OFF_EP0_LIMIT, 32'h2);
      xfer(1, OFF_EP0_CSR, cmd);
      wait_ev();
      xfer(0, OFF_EP0_CSR, 0);
      `CHK(q[7:0], cmd[7:0] | 8'h80)
      xfer(1, OFF_EP0_CSR, cmd);
      wait_ev();
      xfer(0, OFF_EP0_CSR, 0);
      `CHK(q[7:0], cmd[7:0] | 8'h80)
      xfer(1, OFF_EP0_CSR, drop);
      xfer(1, OFF_EP0_CSR, 32'h00);
      t0 = n_tok;
      repeat (100) @(posedge core_clk);
      `CHK(n_tok - t0, 0)
   endtask
   // Acknowledged OUT data, then an IN status stage
   task t_out();
      rsp <= RESP_ACK;
      xfer(1, OFF_EP0_FIFO, 32'h1234_5678);
      xfer(1, OFF_EP0_CSR, 32'h02);
      wait_ev();
      `CHK(kind_q, TOK_OUT)
      `CHK(tx_e, 1'b1)
      xfer(0, OFF_EP0_CSR, 0);
      `CHK(q[7:0], 8'h00)
      rsp <= RESP_DATA;
      xfer(1, OFF_EP0_CSR, 32'h60);
      wait_ev();
      xfer(0, OFF_EP0_CSR, 0);
      `CHK({kind_q, q[7:0]}, {TOK_IN, 8'h01})
      xfer(1, OFF_EP0_CSR, 32'h00);
   endtask
   // Bulk IN with DMA, auto request and a double buffer
   task t_bulk();
      int t0, e0;
      rsp <= RESP_DATA;
      xfer(1, OFF_RX_FIFO_SIZE, 32'h10);
      xfer(1, OFF_AUTO_REQ, 32'h1);
      t0 = n_tok;
      e0 = n_rxev;
      xfer(1, OFF_RX_CSR, 32'h2020);
      repeat (20) @(posedge core_clk);
      `CHK({dreq, rxep_q}, 2'b11)
      dma_done <= 1'b1;
      @(posedge core_clk);
      dma_done <= 1'b0;
      repeat (20) @(posedge core_clk);
      `CHK(n_tok - t0, 2)
      xfer(1, OFF_RX_CSR, 32'h2021);
      repeat (20) @(posedge core_clk);
      xfer(1, OFF_RX_CSR, 32'h2021);
      repeat (20) @(posedge core_clk);
      `CHK(n_tok - t0, 3)
      `CHK(n_rxev - e0, 0)
   endtask
   task give_verdict();
      if (num_errors == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      t_in_data();
      t_stall();
      t_silent(32'h20);
      t_silent(32'h02);
      t_silent(32'h42);
      t_nak(32'h20, 32'h80);
      t_nak(32'h60, 32'h80);
      t_nak(32'h02, 32'h180);
      t_out();
      t_bulk();
      give_verdict();
   end
   // Whole run needs under a thousand cycles
   initial begin
      #1_000_000;
      num_errors++;
      give_verdict();
   end
endmodule
